// [verilog/ctd_dispatch.sv]
`timescale 1ns/10ps
module ctd_dispatch #(
  parameter int PER0_CYC = ctd_pkg::PER0_CYC,
  parameter int PER1_CYC = ctd_pkg::PER1_CYC,
  parameter int PER2_CYC = ctd_pkg::PER2_CYC,
  parameter int PER3_CYC = ctd_pkg::PER3_CYC,
  parameter int PER4_CYC = ctd_pkg::PER4_CYC
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // async reset, high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_host_ready_flag, // host ready flag pin
  input wire logic [ctd_pkg::CNT_W-1:0] i_norm_cnt, // normal consecutive count
  input wire logic [ctd_pkg::IRQ_N-1:0] i_irq_route_nmi, // 1: input goes to nmi
  input wire logic [ctd_pkg::IRQ_N-1:0] i_external_irq_inputs, // interrupt pins
  input wire logic i_host_irq_instruction, // host interrupt pulse
  input wire logic [ctd_pkg::IRQ_N-1:0] i_host_irq_sel, // host interrupt numbers
  input wire ctd_pkg::ctd_prog_cfg_t [ctd_pkg::PROG_N-1:0] i_prog_cfg, // per program
  input wire logic [ctd_pkg::PROG_N-1:0] i_prog_active, // program has active steps
  input wire logic i_main_free, // main cycle has free time
  input wire logic i_op_done, // engine finished one basic operation
  input wire logic i_op_trans, // that operation moved the active step
  input wire logic i_op_motion, // reached step is a motion step
  input wire logic i_op_finish, // program ended
  input wire logic i_op_mask, // event_mask_instr executed
  input wire logic i_op_unmask, // event_unmask_instr executed
  output logic o_run_valid, // engine may run basic operations
  output ctd_pkg::ctd_cls_t o_run_cls, // class of running program
  output logic [ctd_pkg::PROG_W-1:0] o_run_prog, // running program number
  output logic [ctd_pkg::CNT_W-1:0] o_run_limit, // operations allowed this cycle
  output logic o_event_masked, // event dispatch blocked
  output logic [ctd_pkg::PROG_N-1:0] o_evt_pending, // latched event triggers
  output logic [ctd_pkg::PROG_N-1:0] o_nmi_pending, // latched nmi triggers
  output logic [ctd_pkg::CNT_W-1:0] o_norm_cnt, // count in use for normal task
  output logic [15:0] o_param_err, // parameter error code
  output logic [15:0] o_prog_err, // program error code
  output logic [ctd_pkg::PROG_W-1:0] o_err_prog, // program that raised it
  output logic o_prog_stop // pulse: program stopped on error
);
  ctd_pkg::ctd_regs_t r_reg;
  ctd_pkg::ctd_regs_t r_next;
  logic [ctd_pkg::PER_N-1:0] tick;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ctd_pkg::PROG_W-1:0] lowest(
    input logic [ctd_pkg::PROG_N-1:0] v);
    logic [ctd_pkg::PROG_W-1:0] idx;
    idx = '0;
    for (int i = ctd_pkg::PROG_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = ctd_pkg::PROG_W'(i);
      end
    end
    return idx;
  endfunction : lowest

  function automatic logic [ctd_pkg::CNT_W-1:0] at_least_one(
    input logic [ctd_pkg::CNT_W-1:0] c);
    return (c == '0) ? ctd_pkg::CNT_W'(1) : c;
  endfunction : at_least_one

  ////////////////////////////////////////////////////////////////////////////
  ctd_period_tick #(.CYCLES(PER0_CYC)) u_tick0 (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_ce(i_ce), .o_tick(tick[0]));
  ctd_period_tick #(.CYCLES(PER1_CYC)) u_tick1 (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_ce(i_ce), .o_tick(tick[1]));
  ctd_period_tick #(.CYCLES(PER2_CYC)) u_tick2 (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_ce(i_ce), .o_tick(tick[2]));
  ctd_period_tick #(.CYCLES(PER3_CYC)) u_tick3 (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_ce(i_ce), .o_tick(tick[3]));
  ctd_period_tick #(.CYCLES(PER4_CYC)) u_tick4 (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_ce(i_ce), .o_tick(tick[4]));

  ////////////////////////////////////////////////////////////////////////////
  logic rdy_rise;
  logic [ctd_pkg::IRQ_N-1:0] irq_rise;
  logic [ctd_pkg::PROG_N-1:0] evt_trig;
  logic [ctd_pkg::PROG_N-1:0] nmi_trig;
  logic [ctd_pkg::PROG_N-1:0] norm_act;
  logic [ctd_pkg::PROG_N-1:0] norm_hi;
  logic [ctd_pkg::PROG_N-1:0] evt_ready;
  logic cnt_ok;
  logic preempt;
  logic [ctd_pkg::CNT_W-1:0] ops_inc;
  logic [ctd_pkg::PROG_W-1:0] sel;

  always_comb begin
    r_next = r_reg;
    r_next.stop = 1'b0;
    sel = '0;
    // first stage only feeds the second stage
    r_next.rdy_s1 = i_host_ready_flag;
    r_next.rdy_s2 = r_reg.rdy_s1;
    r_next.rdy_d = r_reg.rdy_s2;
    r_next.irq_s1 = i_external_irq_inputs;
    r_next.irq_s2 = r_reg.irq_s1;
    r_next.irq_d = r_reg.irq_s2;
    rdy_rise = r_reg.rdy_s2 & ~r_reg.rdy_d;
    irq_rise = r_reg.irq_s2 & ~r_reg.irq_d;

    // parameters are taken only on the off-to-on edge of the ready flag
    cnt_ok = (i_norm_cnt >= ctd_pkg::NORM_CNT_MIN) && (i_norm_cnt <= ctd_pkg::NORM_CNT_MAX);
    if (rdy_rise) begin
      r_next.irq_nmi = i_irq_route_nmi;
      if (cnt_ok) begin
        r_next.norm_cnt = i_norm_cnt;
        r_next.param_err = ctd_pkg::ERR_NONE;
      end else begin
        r_next.norm_cnt = ctd_pkg::NORM_CNT_INIT;
        r_next.param_err = ctd_pkg::ERR_NORM_CNT;
      end
    end

    // period, host and non-nmi pin triggers fan out to every event program that lists them, nmi pins to
    // every nmi program that lists them; one period field per program keeps a second fixed period unrepresentable
    for (int p = 0; p < ctd_pkg::PROG_N; p++) begin
      evt_trig[p] = 1'b0;
      nmi_trig[p] = 1'b0;
      norm_act[p] = i_prog_active[p] && (i_prog_cfg[p].cls == ctd_pkg::CLS_NORMAL);
      if (r_reg.rdy_d) begin
        if (i_prog_cfg[p].cls == ctd_pkg::CLS_EVENT) begin
          evt_trig[p] = ((i_prog_cfg[p].per != ctd_pkg::PER_NONE) &&
              (i_prog_cfg[p].per <= 3'(ctd_pkg::PER_N)) &&
              tick[i_prog_cfg[p].per - 3'h1]) ||
            (|(i_prog_cfg[p].ext & irq_rise & ~r_reg.irq_nmi)) ||
            (i_host_irq_instruction && |(i_prog_cfg[p].host & i_host_irq_sel));
        end
        if (i_prog_cfg[p].cls == ctd_pkg::CLS_NMI) begin
          nmi_trig[p] = |(i_prog_cfg[p].ext & irq_rise & r_reg.irq_nmi);
        end
      end
    end
    evt_ready = r_reg.evt_pend & {ctd_pkg::PROG_N{~r_reg.evt_mask}};
    norm_hi = norm_act & ~((ctd_pkg::PROG_N'(1) << r_reg.rr) - ctd_pkg::PROG_N'(1));
    ops_inc = r_reg.ops + 1'b1;
    preempt = (|r_reg.nmi_pend) ||
      ((r_reg.cls == ctd_pkg::CLS_NORMAL) && (|evt_ready));

    case (r_reg.st)
      ctd_pkg::ST_IDLE: begin
        r_next.ops = '0;
        if (|r_reg.nmi_pend) begin
          sel = lowest(r_reg.nmi_pend);
          r_next.nmi_pend[sel] = 1'b0;
          r_next.cls = ctd_pkg::CLS_NMI;
          r_next.limit = at_least_one(i_prog_cfg[sel].cnt);
          r_next.prog = sel;
          r_next.st = ctd_pkg::ST_RUN;
        end else if (|evt_ready) begin
          sel = lowest(evt_ready);
          r_next.evt_pend[sel] = 1'b0;
          r_next.cls = ctd_pkg::CLS_EVENT;
          r_next.limit = at_least_one(i_prog_cfg[sel].cnt);
          r_next.prog = sel;
          r_next.st = ctd_pkg::ST_RUN;
        end else if (i_main_free && (|norm_act)) begin
          // rotate so one busy normal program cannot starve the rest
          sel = (|norm_hi) ? lowest(norm_hi) : lowest(norm_act);
          r_next.rr = sel + 1'b1;
          r_next.cls = ctd_pkg::CLS_NORMAL;
          r_next.limit = r_reg.norm_cnt;
          r_next.prog = sel;
          r_next.st = ctd_pkg::ST_RUN;
        end
      end
      ctd_pkg::ST_RUN: begin
        if (i_op_done) begin
          r_next.ops = ops_inc;
          if (r_reg.cls == ctd_pkg::CLS_NORMAL) begin
            if (i_op_mask) begin
              r_next.evt_mask = 1'b1;
            end else if (i_op_unmask) begin
              r_next.evt_mask = 1'b0;
            end
          end
          if (i_op_motion && (r_reg.cls != ctd_pkg::CLS_NORMAL)) begin
            r_next.prog_err = ctd_pkg::ERR_MOTION_STEP;
            r_next.err_prog = r_reg.prog;
            r_next.stop = 1'b1;
            r_next.st = ctd_pkg::ST_IDLE;
          end else if (i_op_finish) begin
            r_next.st = ctd_pkg::ST_IDLE;
          end else if (i_op_trans && (ops_inc < r_reg.limit) && !preempt) begin
            r_next.st = ctd_pkg::ST_RUN;
          end else begin
            r_next.st = ctd_pkg::ST_IDLE;
            // a pre-empted event program resumes later from its pending bit
            if (preempt && (r_reg.cls == ctd_pkg::CLS_EVENT) && i_op_trans &&
                (ops_inc < r_reg.limit)) begin
              r_next.evt_pend[r_reg.prog] = 1'b1;
            end
          end
        end
      end
      default: begin
        r_next.st = ctd_pkg::ST_IDLE;
      end
    endcase

    // new triggers win over the dispatch clear above
    r_next.evt_pend = r_next.evt_pend | evt_trig;
    r_next.nmi_pend = r_next.nmi_pend | nmi_trig;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '0;
      r_reg.norm_cnt <= ctd_pkg::NORM_CNT_INIT;
      r_reg.limit <= ctd_pkg::NORM_CNT_INIT;
      r_reg.irq_nmi <= ctd_pkg::IRQ_ROUTE_INIT;
      r_reg.param_err <= ctd_pkg::ERR_NONE;
      r_reg.prog_err <= ctd_pkg::ERR_NONE;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_run_valid = (r_reg.st == ctd_pkg::ST_RUN);
  assign o_run_cls = r_reg.cls;
  assign o_run_prog = r_reg.prog;
  assign o_run_limit = r_reg.limit;
  assign o_event_masked = r_reg.evt_mask;
  assign o_evt_pending = r_reg.evt_pend;
  assign o_nmi_pending = r_reg.nmi_pend;
  assign o_norm_cnt = r_reg.norm_cnt;
  assign o_param_err = r_reg.param_err;
  assign o_prog_err = r_reg.prog_err;
  assign o_err_prog = r_reg.err_prog;
  assign o_prog_stop = r_reg.stop;

  ////////////////////////////////////////////////////////////////////////////
  logic idle_ce;
  assign idle_ce = i_ce && (r_reg.st == ctd_pkg::ST_IDLE);

  nmi_first_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce && (|r_reg.nmi_pend) |=> o_run_valid && (o_run_cls == ctd_pkg::CLS_NMI))
    else $error("pending nmi not dispatched first");

  nmi_unmasked_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce && r_reg.evt_mask && (|r_reg.nmi_pend) |=> o_run_cls == ctd_pkg::CLS_NMI)
    else $error("nmi blocked by event mask");

  event_blocked_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce && r_reg.evt_mask |=> !(o_run_valid && (o_run_cls == ctd_pkg::CLS_EVENT)))
    else $error("event dispatched while masked");

  event_latched_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce && r_reg.evt_mask && (|r_reg.evt_pend) && !(|r_reg.nmi_pend)
      |=> (o_evt_pending & $past(r_reg.evt_pend)) == $past(r_reg.evt_pend))
    else $error("masked event lost");

  event_order_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce && !r_reg.evt_mask && (|r_reg.evt_pend) && !(|r_reg.nmi_pend)
      |=> o_run_prog == lowest($past(r_reg.evt_pend)))
    else $error("event order not lowest first");

  motion_err_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && o_run_valid && (o_run_cls != ctd_pkg::CLS_NORMAL) && i_op_done && i_op_motion
      |=> o_prog_stop && !o_run_valid && (o_prog_err == ctd_pkg::ERR_MOTION_STEP))
    else $error("motion step in event or nmi not stopped");

  param_err_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && rdy_rise && !cnt_ok
      |=> (o_param_err == ctd_pkg::ERR_NORM_CNT) && (o_norm_cnt == ctd_pkg::NORM_CNT_INIT))
    else $error("bad normal count not replaced");

  op_limit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_run_valid |-> r_reg.ops < r_reg.limit)
    else $error("consecutive operations exceed limit");

  cycle_end_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && o_run_valid && i_op_done && !i_op_trans |=> !o_run_valid)
    else $error("cycle continued without a transition");

  normal_suspend_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && o_run_valid && (o_run_cls == ctd_pkg::CLS_NORMAL) && i_op_done &&
      (|r_reg.nmi_pend) |=> !o_run_valid ##1 (o_run_cls == ctd_pkg::CLS_NMI))
    else $error("normal task not suspended");

  normal_free_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    idle_ce ##1 (o_run_valid && (o_run_cls == ctd_pkg::CLS_NORMAL)) |-> $past(i_main_free))
    else $error("normal task ran without free time");

  nmi_run_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    o_run_valid && (o_run_cls == ctd_pkg::CLS_NMI));
  chain_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    o_run_valid && (r_reg.ops == ctd_pkg::CNT_W'(2)));
  masked_wait_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    o_event_masked && (|o_evt_pending));
  param_err_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    o_param_err == ctd_pkg::ERR_NORM_CNT);
endmodule : ctd_dispatch

// [inc/ctd_pkg.sv]
package ctd_pkg;
  localparam int PROG_N = 8;
  localparam int PROG_W = 3;
  localparam int IRQ_N = 16;
  localparam int CNT_W = 5;
  localparam int TICK_W = 24;
  localparam int CLK_NS = 8;
  localparam logic [CNT_W-1:0] NORM_CNT_MIN = 5'h01;
  localparam logic [CNT_W-1:0] NORM_CNT_MAX = 5'h1e;
  localparam logic [CNT_W-1:0] NORM_CNT_INIT = 5'h03;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_MOTION_STEP = 16'h3ef1;
  localparam logic [15:0] ERR_NORM_CNT = 16'h4268;
  localparam logic [IRQ_N-1:0] IRQ_ROUTE_INIT = 16'h0000;
  localparam logic [2:0] PER_NONE = 3'h0;
  localparam int PER_N = 5;
  localparam int PER0_NS = 880_000;
  localparam int PER1_NS = 1_770_000;
  localparam int PER2_NS = 3_550_000;
  localparam int PER3_NS = 7_110_000;
  localparam int PER4_NS = 14_200_000;
  localparam int PER0_CYC = PER0_NS / CLK_NS;
  localparam int PER1_CYC = PER1_NS / CLK_NS;
  localparam int PER2_CYC = PER2_NS / CLK_NS;
  localparam int PER3_CYC = PER3_NS / CLK_NS;
  localparam int PER4_CYC = PER4_NS / CLK_NS;

  typedef enum logic [1:0] {CLS_NORMAL, CLS_EVENT, CLS_NMI} ctd_cls_t;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ctd_state_t;

  // per[]: 0 none, 1..5 selects one of the five periods
  typedef struct packed {
    ctd_cls_t cls;
    logic [2:0] per;
    logic [IRQ_N-1:0] ext;
    logic [IRQ_N-1:0] host;
    logic [CNT_W-1:0] cnt;
  } ctd_prog_cfg_t;

  typedef struct packed {
    ctd_state_t st;
    ctd_cls_t cls;
    logic [PROG_W-1:0] prog;
    logic [CNT_W-1:0] ops;
    logic [CNT_W-1:0] limit;
    logic [PROG_W-1:0] rr;
    logic evt_mask;
    logic [PROG_N-1:0] evt_pend;
    logic [PROG_N-1:0] nmi_pend;
    logic [CNT_W-1:0] norm_cnt;
    logic [IRQ_N-1:0] irq_nmi;
    logic [15:0] param_err;
    logic [15:0] prog_err;
    logic [PROG_W-1:0] err_prog;
    logic stop;
    logic rdy_s1;
    logic rdy_s2;
    logic rdy_d;
    logic [IRQ_N-1:0] irq_s1;
    logic [IRQ_N-1:0] irq_s2;
    logic [IRQ_N-1:0] irq_d;
  } ctd_regs_t;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } ctd_tick_t;
endpackage : ctd_pkg

// [verilog/ctd_period_tick.sv]
`timescale 1ns/10ps
module ctd_period_tick #(
  parameter int CYCLES = ctd_pkg::PER0_CYC
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // async reset, high
  input wire logic i_ce, // clock enable
  output logic o_tick // one-cycle pulse per period
);
  ctd_pkg::ctd_tick_t r_reg;
  ctd_pkg::ctd_tick_t r_next;
  localparam logic [ctd_pkg::TICK_W-1:0] LAST = ctd_pkg::TICK_W'(CYCLES - 1);

  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == LAST) begin
      r_next.cnt = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_tick = r_reg.tick;
endmodule : ctd_period_tick

// [test/ctd_engine_model.sv]
`timescale 1ns/10ps
module ctd_engine_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // async reset, high
  input wire logic i_run_valid, // grant from dispatcher
  input wire logic i_slow, // answer every other cycle
  input wire logic [4:0] i_qual, // trans, motion, finish, mask, unmask
  output logic o_op_done, // one basic operation ended
  output logic [4:0] o_qual // qualifiers of that operation
);
  logic phase_reg;
  // falling edge drive keeps the dispatcher's sampling edge race free
  always @(negedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      phase_reg <= 1'b0;
      o_op_done <= 1'b0;
      o_qual <= 5'h00;
    end else begin
      phase_reg <= ~phase_reg;
      o_op_done <= i_run_valid && (!i_slow || phase_reg);
      // junk outside an operation, so a stale copy can never pass for valid
      o_qual <= (i_run_valid && (!i_slow || phase_reg)) ? i_qual : ~o_qual;
    end
  end
endmodule : ctd_engine_model

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rdy = 1'b0;
  logic [4:0] ncnt = 5'h00;
  logic hirq = 1'b0;
  logic [15:0] pins = 16'h0000;
  ctd_pkg::ctd_prog_cfg_t [7:0] cfg = '0;
  logic [7:0] act = 8'h00;
  logic free = 1'b0;
  logic slow = 1'b0;
  logic [4:0] qual = 5'h00; // trans, motion, finish, mask, unmask
  logic ce = 1'b1;
  logic [15:0] route = 16'h0008;
  logic [15:0] hsel = 16'h0001;
  logic op_done, run_valid, masked, stop;
  logic [4:0] oq, run_limit, norm_cnt;
  ctd_pkg::ctd_cls_t run_cls;
  logic [2:0] run_prog, err_prog;
  logic [7:0] evt_pend, nmi_pend;
  logic [15:0] perr, prog_err;
  int fail_count = 0;
  int total_checks = 0;
  int norm_ops = 0;
  int stop_cnt = 0;
  int n;
  int k;
  logic prev_v = 1'b0;
  logic [9:0] seen_q[$];
  // ready-rise rows: count driven, count in use, error code
  logic [25:0] rows [5] = '{{5'h00, 5'h03, 16'h4268}, {5'h1f, 5'h03, 16'h4268},
    {5'h1e, 5'h1e, 16'h0000}, {5'h01, 5'h01, 16'h0000}, {5'h04, 5'h04, 16'h0000}};

  ctd_dispatch #(.PER0_CYC(20), .PER1_CYC(40), .PER2_CYC(80), .PER3_CYC(160),
    .PER4_CYC(320)) u_dut (.i_clk_sys(clk), .i_reset(rst), .i_ce(ce),
    .i_host_ready_flag(rdy), .i_norm_cnt(ncnt), .i_irq_route_nmi(route),
    .i_external_irq_inputs(pins), .i_host_irq_instruction(hirq),
    .i_host_irq_sel(hsel), .i_prog_cfg(cfg), .i_prog_active(act), .i_main_free(free),
    .i_op_done(op_done), .i_op_trans(oq[4]), .i_op_motion(oq[3]), .i_op_finish(oq[2]),
    .i_op_mask(oq[1]), .i_op_unmask(oq[0]), .o_run_valid(run_valid), .o_run_cls(run_cls),
    .o_run_prog(run_prog), .o_run_limit(run_limit), .o_event_masked(masked),
    .o_evt_pending(evt_pend), .o_nmi_pending(nmi_pend), .o_norm_cnt(norm_cnt),
    .o_param_err(perr), .o_prog_err(prog_err), .o_err_prog(err_prog), .o_prog_stop(stop));

  ctd_engine_model u_eng (.i_clk_sys(clk), .i_reset(rst), .i_run_valid(run_valid),
    .i_slow(slow), .i_qual(qual), .o_op_done(op_done), .o_qual(oq));

  ////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end

  // dispatch log, read before the edge's updates land
  always @(posedge clk) begin
    if (run_valid && !prev_v && run_cls != ctd_pkg::CLS_NORMAL) begin
      seen_q.push_back({run_cls, run_prog, run_limit});
    end
    if (run_valid && op_done && run_cls == ctd_pkg::CLS_NORMAL) norm_ops++;
    if (stop) stop_cnt++;
    prev_v = run_valid;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reset_checks;
    chk(run_valid, 1'b0);
    chk(masked, 1'b0);
    chk(evt_pend, 8'h00);
    chk(norm_cnt, 5'h03);
    chk(perr, 16'h0000);
  endtask : reset_checks

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  function automatic ctd_pkg::ctd_prog_cfg_t mk(input ctd_pkg::ctd_cls_t c,
      input logic [2:0] p, input logic [15:0] e, input logic [15:0] h, input logic [4:0] m);
    mk = {c, p, e, h, m};
  endfunction : mk

  ////////////////////////////////////////////////////////////
  initial begin
    #100_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    cfg[1] = mk(ctd_pkg::CLS_EVENT, 3'h0, 16'h0000, 16'h0001, 5'h02);
    cfg[2] = mk(ctd_pkg::CLS_EVENT, 3'h0, 16'h0020, 16'h0001, 5'h01);
    cfg[4] = mk(ctd_pkg::CLS_NMI, 3'h0, 16'h0008, 16'h0000, 5'h01);
    cfg[5] = mk(ctd_pkg::CLS_EVENT, 3'h0, 16'h0000, 16'h0000, 5'h01);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reset_checks();
    $display("reset test done");
    for (k = 0; k < 5; k++) begin
      rdy = 1'b0;
      repeat (2) @(negedge clk);
      ncnt = rows[k][25:21];
      rdy = 1'b1;
      repeat (6) @(negedge clk);
      chk(norm_cnt, rows[k][20:16]);
      chk(perr, rows[k][15:0]);
    end
    $display("parameter capture test done");
    act = 8'h01;
    qual = 5'h10;
    slow = 1'b1;
    repeat (10) @(negedge clk);
    chk(run_valid, 1'b0);
    free = 1'b1;
    for (n = 0; n < 20 && !run_valid; n++) @(negedge clk);
    chk(run_cls, ctd_pkg::CLS_NORMAL);
    chk(run_limit, 5'h04);
    k = norm_ops;
    for (n = 0; n < 50 && run_valid; n++) @(negedge clk);
    chk(norm_ops - k, 4);
    $display("normal task test done");
    slow = 1'b0;
    qual = 5'h12;
    for (n = 0; n < 50 && !masked; n++) @(negedge clk);
    qual = 5'h10;
    chk(masked, 1'b1);
    hirq = 1'b1;
    @(negedge clk);
    hirq = 1'b0;
    repeat (3) @(negedge clk);
    chk(evt_pend, 8'h06);
    seen_q.delete();
    pins = 16'h0008;
    repeat (12) @(negedge clk);
    chk(evt_pend, 8'h06);
    chk(seen_q.size(), 1);
    qual = 5'h11;
    for (n = 0; n < 50 && masked; n++) @(negedge clk);
    qual = 5'h10;
    pins = 16'h0000;
    repeat (40) @(negedge clk);
    chk(seen_q.size(), 3);
    chk(seen_q[0], {ctd_pkg::CLS_NMI, 3'h4, 5'h01});
    chk(seen_q[1], {ctd_pkg::CLS_EVENT, 3'h1, 5'h02});
    chk(seen_q[2], {ctd_pkg::CLS_EVENT, 3'h2, 5'h01});
    $display("mask and priority test done");
    qual = 5'h18;
    k = stop_cnt;
    pins = 16'h0020;
    repeat (20) @(negedge clk);
    chk(prog_err, ctd_pkg::ERR_MOTION_STEP);
    chk(err_prog, 3'h2);
    pins = 16'h0008;
    repeat (20) @(negedge clk);
    chk(err_prog, 3'h4);
    chk(stop_cnt - k, 2);
    $display("motion step test done");
    qual = 5'h10;
    pins = 16'h0000;
    seen_q.delete();
    cfg[5].per = 3'h1;
    repeat (70) @(negedge clk);
    chk(seen_q.size() >= 2, 1'b1);
    chk(seen_q[0], {ctd_pkg::CLS_EVENT, 3'h5, 5'h01});
    $display("period test done");
    ce = 1'b0;
    k = seen_q.size();
    repeat (400) @(negedge clk);
    chk(seen_q.size(), k);
    ce = 1'b1;
    $display("clock enable test done");
    rst = 1'b1;
    @(negedge clk);
    reset_checks();
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : tb_top
